/* design/pbe_consts.svh */
// Purpose: constants for the precharge buffer enable register bank
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: printed offsets are register indices; byte address is four times the index
`ifndef PBE_CONSTS_SVH
`define PBE_CONSTS_SVH

// ----------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------
`define PBE_IDX_IN_LO 8'h11
`define PBE_IDX_IN_HI 8'h12
`define PBE_IDX_REF_POS 8'h13
`define PBE_IDX_REF_NEG 8'h14

// ----------------------------------------
// reset values
// ----------------------------------------
`define PBE_RST_IN_LO 8'hFF
`define PBE_RST_IN_HI 8'hFF
`define PBE_RST_REF_POS 8'h00
`define PBE_RST_REF_NEG 8'h00

// ----------------------------------------
// bus layout
// ----------------------------------------
`define PBE_ADDR_W 12
`define PBE_DATA_W 32
`define PBE_REG_W 8
`define PBE_IDX_LSB 2
`define PBE_IDX_MSB 9
`define PBE_BYTE_LANE0 0

`endif

/* design/pbe_pkg.sv */
// Purpose: shared types of the precharge buffer enable register bank
// Assumes: constants live in pbe_consts.svh
// Notes: none
package pbe_pkg;

  typedef logic [7:0] pbe_byte_t;

  typedef enum logic [2:0] {
    PBE_SEL_NONE,
    PBE_SEL_IN_LO,
    PBE_SEL_IN_HI,
    PBE_SEL_REF_POS,
    PBE_SEL_REF_NEG
  } pbe_sel_t;

endpackage

/* design/pbe_reg8.sv */
// Purpose: one 8-bit enable register, optionally storing the complement of the written byte
// Assumes: write strobe is a single-cycle pulse on clock
// Notes: reads return the stored byte as is
`timescale 1ns/1ps
`default_nettype none

module pbe_reg8 #(
  parameter pbe_pkg::pbe_byte_t RESET_VALUE = 8'h00,
  parameter bit INVERT_ON_WRITE = 1'b0
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // write side
  input wire logic wr_en,
  input wire pbe_pkg::pbe_byte_t wr_data,
  // stored value
  output pbe_pkg::pbe_byte_t value
);

  pbe_pkg::pbe_byte_t value_reg;
  pbe_pkg::pbe_byte_t value_next;
  pbe_pkg::pbe_byte_t store_data;

  // reference registers keep the byte as written
  assign store_data = INVERT_ON_WRITE ? ~wr_data : wr_data;
  assign value_next = wr_en ? store_data : value_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      value_reg <= RESET_VALUE;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;

endmodule

`default_nettype wire

/* design/pbe_regs.sv */
// Purpose: APB register bank that switches per-channel precharge buffers on and off
// Assumes: APB master holds address and data through the access phase
// Notes: zero wait states; unmapped addresses answer with pslverr and change nothing
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "pbe_consts.svh"

module pbe_regs (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PBE_ADDR_W-1:0] paddr,
  input wire logic [`PBE_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [`PBE_DATA_W-1:0] prdata,
  output logic pslverr,
  // analog input buffer enables, one bit per channel
  output logic [7:0] chan_pos_input_buffer_on,
  output logic [7:0] chan_neg_input_buffer_on,
  // reference buffer enables, one bit per channel
  output logic [7:0] chan_pos_reference_buffer_on,
  output logic [7:0] chan_neg_reference_buffer_on
);

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  function automatic pbe_pkg::pbe_sel_t decode_sel(input logic [`PBE_ADDR_W-1:0] addr);
    logic [7:0] idx;
    logic aligned;
    pbe_pkg::pbe_sel_t sel;
    idx = addr[`PBE_IDX_MSB:`PBE_IDX_LSB];
    aligned = (addr[1:0] == 2'h0) && (addr[`PBE_ADDR_W-1:`PBE_IDX_MSB+1] == 2'h0);
    sel = pbe_pkg::PBE_SEL_NONE;
    if (aligned && idx == `PBE_IDX_IN_LO) begin
      sel = pbe_pkg::PBE_SEL_IN_LO;
    end else if (aligned && idx == `PBE_IDX_IN_HI) begin
      sel = pbe_pkg::PBE_SEL_IN_HI;
    end else if (aligned && idx == `PBE_IDX_REF_POS) begin
      sel = pbe_pkg::PBE_SEL_REF_POS;
    end else if (aligned && idx == `PBE_IDX_REF_NEG) begin
      sel = pbe_pkg::PBE_SEL_REF_NEG;
    end
    return sel;
  endfunction

  // picks every other bit starting at the given phase: 0 gives positive, 1 negative
  function automatic logic [3:0] pick_pairs(input pbe_pkg::pbe_byte_t b, input logic phase);
    logic [3:0] r;
    r = 4'h0;
    for (int k = 0; k < 4; k++) begin
      r[k] = phase ? b[2*k+1] : b[2*k];
    end
    return r;
  endfunction

  // read selection; an address that decodes to no register reads as zero
  function automatic pbe_pkg::pbe_byte_t read_byte(
    input pbe_pkg::pbe_sel_t s,
    input pbe_pkg::pbe_byte_t lo,
    input pbe_pkg::pbe_byte_t hi,
    input pbe_pkg::pbe_byte_t rp,
    input pbe_pkg::pbe_byte_t rn
  );
    pbe_pkg::pbe_byte_t r;
    r = 8'h00;
    if (s == pbe_pkg::PBE_SEL_IN_LO) begin
      r = lo;
    end else if (s == pbe_pkg::PBE_SEL_IN_HI) begin
      r = hi;
    end else if (s == pbe_pkg::PBE_SEL_REF_POS) begin
      r = rp;
    end else if (s == pbe_pkg::PBE_SEL_REF_NEG) begin
      r = rn;
    end
    return r;
  endfunction

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  pbe_pkg::pbe_sel_t sel;
  wire setup_phase;
  wire access_done;
  wire lane0_write;
  wire wr_in_lo;
  wire wr_in_hi;
  wire wr_ref_pos;
  wire wr_ref_neg;
  pbe_pkg::pbe_byte_t wr_byte;

  assign sel = decode_sel(paddr);
  assign setup_phase = psel && !penable;
  // every access completes in its first access cycle
  assign pready = 1'b1;
  assign access_done = psel && penable && pready;
  // registers are 8 bits wide, so only byte lane 0 carries a write
  assign lane0_write = access_done && pwrite && pstrb[`PBE_BYTE_LANE0];
  assign wr_byte = pwdata[`PBE_REG_W-1:0];
  // writing 0x01 to the low register stores 0xFE: one enable cleared, the other seven set
  assign wr_in_lo = lane0_write && (sel == pbe_pkg::PBE_SEL_IN_LO);
  assign wr_in_hi = lane0_write && (sel == pbe_pkg::PBE_SEL_IN_HI);
  assign wr_ref_pos = lane0_write && (sel == pbe_pkg::PBE_SEL_REF_POS);
  assign wr_ref_neg = lane0_write && (sel == pbe_pkg::PBE_SEL_REF_NEG);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  pbe_pkg::pbe_byte_t in_lo_val;
  pbe_pkg::pbe_byte_t in_hi_val;
  pbe_pkg::pbe_byte_t ref_pos_val;
  pbe_pkg::pbe_byte_t ref_neg_val;

  pbe_reg8 #(
    .RESET_VALUE(`PBE_RST_IN_LO),
    .INVERT_ON_WRITE(1'b1)
  ) u_in_lo (
    .clock(clock),
    .arst_n(arst_n),
    .wr_en(wr_in_lo),
    .wr_data(wr_byte),
    .value(in_lo_val)
  );

  pbe_reg8 #(
    .RESET_VALUE(`PBE_RST_IN_HI),
    .INVERT_ON_WRITE(1'b1)
  ) u_in_hi (
    .clock(clock),
    .arst_n(arst_n),
    .wr_en(wr_in_hi),
    .wr_data(wr_byte),
    .value(in_hi_val)
  );

  pbe_reg8 #(
    .RESET_VALUE(`PBE_RST_REF_POS),
    .INVERT_ON_WRITE(1'b0)
  ) u_ref_pos (
    .clock(clock),
    .arst_n(arst_n),
    .wr_en(wr_ref_pos),
    .wr_data(wr_byte),
    .value(ref_pos_val)
  );

  pbe_reg8 #(
    .RESET_VALUE(`PBE_RST_REF_NEG),
    .INVERT_ON_WRITE(1'b0)
  ) u_ref_neg (
    .clock(clock),
    .arst_n(arst_n),
    .wr_en(wr_ref_neg),
    .wr_data(wr_byte),
    .value(ref_neg_val)
  );

  // ----------------------------------------
  // buffer controls
  // ----------------------------------------
  // even bits of an input byte drive positive buffers, odd bits negative
  wire [3:0] lo_pos_bits;
  wire [3:0] lo_neg_bits;
  wire [3:0] hi_pos_bits;
  wire [3:0] hi_neg_bits;

  assign lo_pos_bits = pick_pairs(in_lo_val, 1'b0);
  assign lo_neg_bits = pick_pairs(in_lo_val, 1'b1);
  assign hi_pos_bits = pick_pairs(in_hi_val, 1'b0);
  assign hi_neg_bits = pick_pairs(in_hi_val, 1'b1);

  // one named enable per buffer keeps the analog hookup readable channel by channel
  wire chan0_pos_input_buffer_on;
  wire chan1_pos_input_buffer_on;
  wire chan2_pos_input_buffer_on;
  wire chan3_pos_input_buffer_on;
  wire chan4_pos_input_buffer_on;
  wire chan5_pos_input_buffer_on;
  wire chan6_pos_input_buffer_on;
  wire chan7_pos_input_buffer_on;
  wire chan0_neg_input_buffer_on;
  wire chan1_neg_input_buffer_on;
  wire chan2_neg_input_buffer_on;
  wire chan3_neg_input_buffer_on;
  wire chan4_neg_input_buffer_on;
  wire chan5_neg_input_buffer_on;
  wire chan6_neg_input_buffer_on;
  wire chan7_neg_input_buffer_on;
  wire chan0_pos_reference_buffer_on;
  wire chan1_pos_reference_buffer_on;
  wire chan2_pos_reference_buffer_on;
  wire chan3_pos_reference_buffer_on;
  wire chan4_pos_reference_buffer_on;
  wire chan5_pos_reference_buffer_on;
  wire chan6_pos_reference_buffer_on;
  wire chan7_pos_reference_buffer_on;
  wire chan0_neg_reference_buffer_on;
  wire chan1_neg_reference_buffer_on;
  wire chan2_neg_reference_buffer_on;
  wire chan3_neg_reference_buffer_on;
  wire chan4_neg_reference_buffer_on;
  wire chan5_neg_reference_buffer_on;
  wire chan6_neg_reference_buffer_on;
  wire chan7_neg_reference_buffer_on;

  // stored 1 means on, with no further gating
  // channels 0 to 3 from the low input byte
  assign chan0_pos_input_buffer_on = lo_pos_bits[0];
  assign chan0_neg_input_buffer_on = lo_neg_bits[0];
  assign chan1_pos_input_buffer_on = lo_pos_bits[1];
  assign chan1_neg_input_buffer_on = lo_neg_bits[1];
  assign chan2_pos_input_buffer_on = lo_pos_bits[2];
  assign chan2_neg_input_buffer_on = lo_neg_bits[2];
  assign chan3_pos_input_buffer_on = lo_pos_bits[3];
  assign chan3_neg_input_buffer_on = lo_neg_bits[3];
  // channels 4 to 7 from the high input byte
  assign chan4_pos_input_buffer_on = hi_pos_bits[0];
  assign chan4_neg_input_buffer_on = hi_neg_bits[0];
  assign chan5_pos_input_buffer_on = hi_pos_bits[1];
  assign chan5_neg_input_buffer_on = hi_neg_bits[1];
  assign chan6_pos_input_buffer_on = hi_pos_bits[2];
  assign chan6_neg_input_buffer_on = hi_neg_bits[2];
  assign chan7_pos_input_buffer_on = hi_pos_bits[3];
  assign chan7_neg_input_buffer_on = hi_neg_bits[3];
  // positive reference, bit n for channel n
  assign chan0_pos_reference_buffer_on = ref_pos_val[0];
  assign chan1_pos_reference_buffer_on = ref_pos_val[1];
  assign chan2_pos_reference_buffer_on = ref_pos_val[2];
  assign chan3_pos_reference_buffer_on = ref_pos_val[3];
  assign chan4_pos_reference_buffer_on = ref_pos_val[4];
  assign chan5_pos_reference_buffer_on = ref_pos_val[5];
  assign chan6_pos_reference_buffer_on = ref_pos_val[6];
  assign chan7_pos_reference_buffer_on = ref_pos_val[7];
  // negative reference, bit n for channel n
  assign chan0_neg_reference_buffer_on = ref_neg_val[0];
  assign chan1_neg_reference_buffer_on = ref_neg_val[1];
  assign chan2_neg_reference_buffer_on = ref_neg_val[2];
  assign chan3_neg_reference_buffer_on = ref_neg_val[3];
  assign chan4_neg_reference_buffer_on = ref_neg_val[4];
  assign chan5_neg_reference_buffer_on = ref_neg_val[5];
  assign chan6_neg_reference_buffer_on = ref_neg_val[6];
  assign chan7_neg_reference_buffer_on = ref_neg_val[7];

  assign chan_pos_input_buffer_on = {
    chan7_pos_input_buffer_on, chan6_pos_input_buffer_on, chan5_pos_input_buffer_on, chan4_pos_input_buffer_on,
    chan3_pos_input_buffer_on, chan2_pos_input_buffer_on, chan1_pos_input_buffer_on, chan0_pos_input_buffer_on
  };
  assign chan_neg_input_buffer_on = {
    chan7_neg_input_buffer_on, chan6_neg_input_buffer_on, chan5_neg_input_buffer_on, chan4_neg_input_buffer_on,
    chan3_neg_input_buffer_on, chan2_neg_input_buffer_on, chan1_neg_input_buffer_on, chan0_neg_input_buffer_on
  };
  assign chan_pos_reference_buffer_on = {
    chan7_pos_reference_buffer_on, chan6_pos_reference_buffer_on, chan5_pos_reference_buffer_on,
    chan4_pos_reference_buffer_on, chan3_pos_reference_buffer_on, chan2_pos_reference_buffer_on,
    chan1_pos_reference_buffer_on, chan0_pos_reference_buffer_on
  };
  assign chan_neg_reference_buffer_on = {
    chan7_neg_reference_buffer_on, chan6_neg_reference_buffer_on, chan5_neg_reference_buffer_on,
    chan4_neg_reference_buffer_on, chan3_neg_reference_buffer_on, chan2_neg_reference_buffer_on,
    chan1_neg_reference_buffer_on, chan0_neg_reference_buffer_on
  };

  // ----------------------------------------
  // read data and error
  // ----------------------------------------
  // captured in the setup cycle so prdata comes from a flop and holds through access
  pbe_pkg::pbe_byte_t rd_mux;
  logic [`PBE_DATA_W-1:0] prdata_reg;
  logic [`PBE_DATA_W-1:0] prdata_next;
  logic pslverr_reg;
  logic pslverr_next;
  // misaligned and out-of-range addresses both decode to no register
  wire unmapped;

  assign rd_mux = read_byte(sel, in_lo_val, in_hi_val, ref_pos_val, ref_neg_val);
  assign unmapped = (sel == pbe_pkg::PBE_SEL_NONE);
  assign prdata_next = setup_phase ? {24'h000000, rd_mux} : prdata_reg;
  assign pslverr_next = setup_phase ? unmapped : pslverr_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;

endmodule

`default_nettype wire

/* dv/pbe_regs_monitor.sv */
// Purpose: port checks on the precharge buffer register bank
// Assumes: zero wait state apb slave
// Notes: bound to every pbe_regs instance
`timescale 1ns/1ps
`default_nettype none
`include "pbe_consts.svh"
module pbe_regs_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PBE_ADDR_W-1:0] paddr,
  input wire logic [`PBE_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic [`PBE_DATA_W-1:0] prdata,
  input wire logic pslverr,
  // buffer enables
  input wire logic [7:0] chan_pos_input_buffer_on,
  input wire logic [7:0] chan_neg_input_buffer_on,
  input wire logic [7:0] chan_pos_reference_buffer_on,
  input wire logic [7:0] chan_neg_reference_buffer_on
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire logic [7:0] lo, hi;
  logic mapped;
  assign mapped = paddr inside {12'h044, 12'h048, 12'h04C, 12'h050};
  // rebuild the stored bytes from the per-channel outputs
  for (genvar k = 0; k < 4; k++) begin : g_pack
    assign lo[2*k] = chan_pos_input_buffer_on[k];
    assign lo[2*k+1] = chan_neg_input_buffer_on[k];
    assign hi[2*k] = chan_pos_input_buffer_on[k+4];
    assign hi[2*k+1] = chan_neg_input_buffer_on[k+4];
  end
  sequence wr_s(a);
    psel && penable && pwrite && pstrb[0] && paddr == a;
  endsequence
  sequence rd_s(a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  wr_lo_inv_a: assert property (wr_s(12'h044) |=> lo == ~$past(pwdata[7:0]))
    else $error("low input register not inverted");
  wr_hi_inv_a: assert property (wr_s(12'h048) |=> hi == ~$past(pwdata[7:0]))
    else $error("high input register not inverted");
  wr_refp_a: assert property (wr_s(12'h04C) |=> chan_pos_reference_buffer_on == $past(pwdata[7:0]))
    else $error("positive reference write wrong");
  wr_refn_a: assert property (wr_s(12'h050) |=> chan_neg_reference_buffer_on == $past(pwdata[7:0]))
    else $error("negative reference write wrong");
  rd_lo_a: assert property (rd_s(12'h044) |=> prdata == {24'h0, $past(lo)})
    else $error("low input read wrong");
  rd_refn_a: assert property (rd_s(12'h050) |=> prdata == {24'h0, $past(chan_neg_reference_buffer_on)})
    else $error("negative reference read wrong");
  unmapped_err_a: assert property (psel && !penable && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (psel && !penable && mapped |=> !pslverr)
    else $error("mapped access refused");
  hold_idle_a: assert property (!(psel && penable && pwrite) |=>
    $stable({lo, hi, chan_pos_reference_buffer_on, chan_neg_reference_buffer_on}))
    else $error("enables changed without write");
  ready_high_a: assert property (pready)
    else $error("pready low");
endmodule
bind pbe_regs pbe_regs_monitor u_mon (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .chan_pos_input_buffer_on(chan_pos_input_buffer_on),
  .chan_neg_input_buffer_on(chan_neg_input_buffer_on), .chan_pos_reference_buffer_on(chan_pos_reference_buffer_on),
  .chan_neg_reference_buffer_on(chan_neg_reference_buffer_on));
`default_nettype wire

/* dv/pbe_regs_tb_top.sv */
// Purpose: self-checking bench for the precharge buffer register bank
// Assumes: zero wait state apb slave
// Notes: expected values come from a shadow copy of the four bytes
`timescale 1ns/1ps
`default_nettype none
module pbe_regs_tb_top;
  logic clock = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 12'h0;
  logic [11:0] at [6] = '{12'h044, 12'h048, 12'h04C, 12'h050, 12'h045, 12'hC44};
  logic [31:0] pwdata = 32'h0, prdata, lf = 32'hD3C8;
  logic [3:0] pstrb = 4'h0;
  logic [7:0] pi, ni, pr, nr, m [4];
  logic [41:0] q [$];
  logic [41:0] e;
  int fails = 0, num_checks = 0, cyc = 0;
  always #4 clock = ~clock;
  pbe_regs uut (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .chan_pos_input_buffer_on(pi), .chan_neg_input_buffer_on(ni), .chan_pos_reference_buffer_on(pr),
    .chan_neg_reference_buffer_on(nr));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // each note holds the read answer and the enables that must stand until this transfer completes
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [1:0] i;
    logic bad;
    i = a[3:2] - 2'h1;
    bad = !(a inside {12'h044, 12'h048, 12'h04C, 12'h050});
    q.push_back({w, bad, bad ? 8'h00 : m[i], m[3], m[2], m[1], m[0]});
    if (w && !bad && s[0]) m[i] = (i < 2'h2) ? ~d[7:0] : d[7:0];
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
  endtask
  task rd_all;
    for (int i = 0; i < 4; i++) apb(1'b0, at[i], 32'h0, 4'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task rst;
    arst_n <= 1'b0;
    m = '{8'hFF, 8'hFF, 8'h00, 8'h00};
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (psel && penable && pready) begin
      e = q.pop_front();
      check({31'h0, pslverr}, {31'h0, e[40]});
      if (!e[41]) check(prdata, {24'h0, e[39:32]});
      // the enables still show the state from before this transfer's own write
      for (int k = 0; k < 8; k++) begin
        check({31'h0, pi[k]}, {31'h0, e[2*k]});
        check({31'h0, ni[k]}, {31'h0, e[2*k+1]});
      end
      check({24'h0, pr}, {24'h0, e[23:16]});
      check({24'h0, nr}, {24'h0, e[31:24]});
    end
    if (cyc == 2000) begin
      fails++;
      tally_and_finish;
    end
  end
  initial begin
    rst;
    rd_all;
    apb(1'b1, 12'h044, 32'h1, 4'h1);
    rd_all;
    // random writes and reads, unmapped and strobe-less ones included
    repeat (60) begin
      lf = lfsr(lf);
      apb(lf[0], at[lf[3:1] % 6], lf, lf[7:4]);
    end
    rd_all;
    rst;
    rd_all;
    tally_and_finish;
  end
endmodule
`default_nettype wire
